// file: src/rsq_transceiver_reset_sequencer.sv
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Contract
// - Four transmit controls from free-running clock
// - Four receive controls from free-running clock
// - Asynchronous inputs pass two-flop synchronisers
// - Transmit tie includes transmitter in full reset
// - Receive tie includes receiver in full reset
// - Shared PLL reset only once
// - Full sequence starts at global reset fall
// - Done raised only after sequence completes
// - Completion waits for user-clock-active input
module rsq_transceiver_reset_sequencer (
  input  wire logic                    clock,            // Free-running clock
  input  wire logic                    sys_rst,          // Async reset, active high
  input  wire logic                    powerGood,        // AND of dual power-good
  input  wire rsq_pkg::rsq_stat_t      txStat,           // Transmit status from duals
  input  wire rsq_pkg::rsq_stat_t      rxStat,           // Receive status from duals
  input  wire logic                    tx_master_user_clock_b, // Transmit master user clock
  input  wire logic                    rx_master_user_clock_b, // Receive master user clock
  input  wire logic                    resetAllReq,      // Global reset pulse
  input  wire logic                    txPllDpReq,       // Transmit PLL and datapath request
  input  wire logic                    txDpReq,          // Transmit datapath request
  input  wire logic                    rxPllDpReq,       // Receive PLL and datapath request
  input  wire logic                    rxDpReq,          // Receive datapath request
  input  wire logic                    txEnabledTie,     // Transmit takes part in full reset
  input  wire logic                    rxEnabledTie,     // Receive takes part in full reset
  input  wire logic                    sharedPllTie,     // One PLL serves both directions
  output rsq_pkg::rsq_ctl_t            txCtl,            // Transmit controls
  output rsq_pkg::rsq_ctl_t            rxCtl,            // Receive controls
  output logic                         txDone,           // Transmit sequence done
  output logic                         rxDone,           // Receive sequence done
  input  wire logic [rsq_pkg::ADDR_W-1:0] s_axi_awaddr,  // Write address
  input  wire logic                    s_axi_awvalid,    // Write address valid
  output logic                         s_axi_awready,    // Write address ready
  input  wire logic [31:0]             s_axi_wdata,      // Write data
  input  wire logic [3:0]              s_axi_wstrb,      // Write strobes
  input  wire logic                    s_axi_wvalid,     // Write data valid
  output logic                         s_axi_wready,     // Write data ready
  output logic [1:0]                   s_axi_bresp,      // Write response
  output logic                         s_axi_bvalid,     // Write response valid
  input  wire logic                    s_axi_bready,     // Write response ready
  input  wire logic [rsq_pkg::ADDR_W-1:0] s_axi_araddr,  // Read address
  input  wire logic                    s_axi_arvalid,    // Read address valid
  output logic                         s_axi_arready,    // Read address ready
  output logic [31:0]                  s_axi_rdata,      // Read data
  output logic [1:0]                   s_axi_rresp,      // Read response
  output logic                         s_axi_rvalid,     // Read data valid
  input  wire logic                    s_axi_rready      // Read data ready
);

  localparam logic [rsq_pkg::CNT_W-1:0] PLL_CNT = rsq_pkg::CNT_W'(rsq_pkg::PLL_RST_CYC - 1);
  localparam logic [rsq_pkg::CNT_W-1:0] DP_CNT  = rsq_pkg::CNT_W'(rsq_pkg::DP_RST_CYC - 1);

  // Every input from outside except the AXI port and sys_rst is treated as asynchronous, ties included
  logic [rsq_pkg::IN_W-1:0] rawIn;
  logic [rsq_pkg::IN_W-1:0] meta_reg;
  logic [rsq_pkg::IN_W-1:0] sync_reg;
  logic [1:0]               uclkPrev_reg;

  assign rawIn = {sharedPllTie, rxEnabledTie, txEnabledTie, rxDpReq, txDpReq,
                  rxPllDpReq, txPllDpReq, resetAllReq,
                  rx_master_user_clock_b, tx_master_user_clock_b,
                  rxStat.userClkActive, txStat.userClkActive,
                  rxStat.resetDone, txStat.resetDone,
                  rxStat.pllLock, txStat.pllLock, powerGood};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg     <= '0;
      sync_reg     <= '0;
      uclkPrev_reg <= '0;
    end else begin
      meta_reg     <= rawIn;
      sync_reg     <= meta_reg;
      uclkPrev_reg <= sync_reg[rsq_pkg::IN_UCLK +: 2];
    end
  end

  // Register-bus request pulses
  logic [rsq_pkg::CTRL_W-1:0] ctrlPulse_reg;

  wire       pwrGood  = sync_reg[rsq_pkg::IN_PGOOD];
  wire [1:0] lockIn   = sync_reg[rsq_pkg::IN_LOCK +: 2];
  wire [1:0] rdoneIn  = sync_reg[rsq_pkg::IN_RDONE +: 2];
  wire [1:0] uactIn   = sync_reg[rsq_pkg::IN_UACT +: 2];
  wire [1:0] uclkEdge = sync_reg[rsq_pkg::IN_UCLK +: 2] ^ uclkPrev_reg;
  wire [1:0] enTie    = sync_reg[rsq_pkg::IN_EN +: 2];
  wire       shared   = sync_reg[rsq_pkg::IN_SHARED];
  // Global reset held high keeps the sequence parked; release is the start
  wire       allLvl   = sync_reg[rsq_pkg::IN_ALL] | ctrlPulse_reg[rsq_pkg::CTRL_ALL];
  wire [1:0] pllReq   = sync_reg[rsq_pkg::IN_PLLREQ +: 2]
                      | {ctrlPulse_reg[rsq_pkg::CTRL_RX_PLL], ctrlPulse_reg[rsq_pkg::CTRL_TX_PLL]};
  wire [1:0] dpReq    = sync_reg[rsq_pkg::IN_DPREQ +: 2]
                      | {ctrlPulse_reg[rsq_pkg::CTRL_RX_DP], ctrlPulse_reg[rsq_pkg::CTRL_TX_DP]};

  rsq_pkg::rsq_state_t       st_reg   [2];
  rsq_pkg::rsq_state_t       stNext   [2];
  logic [rsq_pkg::CNT_W-1:0] cnt_reg  [2];
  logic [rsq_pkg::CNT_W-1:0] cntNext  [2];
  logic [1:0]                skip_reg;
  logic [1:0]                skipNext;
  logic [1:0]                full_reg;
  logic [1:0]                fullNext;
  logic [1:0]                seen_reg;
  logic [1:0]                seenNext;
  rsq_pkg::rsq_ctl_t         ctl_reg  [2];
  rsq_pkg::rsq_ctl_t         ctlNext  [2];
  logic [1:0]                done_reg;

  for (genvar d = 0; d < 2; d++) begin : g_dir
    always_comb begin
      stNext[d]   = st_reg[d];
      cntNext[d]  = cnt_reg[d];
      skipNext[d] = skip_reg[d];
      fullNext[d] = full_reg[d];
      seenNext[d] = seen_reg[d] | uclkEdge[d];
      if (allLvl && enTie[d]) begin
        stNext[d]   = rsq_pkg::ST_PWR;
        fullNext[d] = 1'b1;
        // Receive side leaves a shared PLL to the transmit side when the transmit side takes part
        skipNext[d] = (d == 1) && shared && enTie[0];
      end else if (pllReq[d]) begin
        stNext[d]   = rsq_pkg::ST_PWR;
        fullNext[d] = 1'b1;
        skipNext[d] = 1'b0;
      end else if (dpReq[d]) begin
        stNext[d]   = rsq_pkg::ST_DP;
        cntNext[d]  = DP_CNT;
        fullNext[d] = 1'b0;
        skipNext[d] = 1'b0;
      end else begin
        unique case (st_reg[d])
          rsq_pkg::ST_IDLE, rsq_pkg::ST_DONE: begin
          end
          rsq_pkg::ST_PWR: begin
            if (pwrGood) begin
              stNext[d]  = rsq_pkg::ST_PLL; // Skipped PLL waits the hold too: no stale lock
              cntNext[d] = PLL_CNT;
            end
          end
          rsq_pkg::ST_PLL: begin
            if (cnt_reg[d] == '0) stNext[d] = rsq_pkg::ST_LOCK;
            else cntNext[d] = cnt_reg[d] - 1'b1;
          end
          rsq_pkg::ST_LOCK: begin
            if (lockIn[d]) begin
              stNext[d]  = rsq_pkg::ST_DP;
              cntNext[d] = DP_CNT;
            end
          end
          rsq_pkg::ST_DP: begin
            if (cnt_reg[d] == '0) begin
              stNext[d]   = rsq_pkg::ST_UCLK;
              seenNext[d] = uclkEdge[d];
            end else begin
              cntNext[d] = cnt_reg[d] - 1'b1;
            end
          end
          rsq_pkg::ST_UCLK: begin
            if (uactIn[d] && seen_reg[d]) stNext[d] = rsq_pkg::ST_RDONE;
          end
          rsq_pkg::ST_RDONE: begin
            if (rdoneIn[d]) stNext[d] = rsq_pkg::ST_DONE;
          end
        endcase
      end
      ctlNext[d].pllReset  = !skipNext[d] && (stNext[d] == rsq_pkg::ST_PWR
                             || stNext[d] == rsq_pkg::ST_PLL);
      ctlNext[d].divReset  = (stNext[d] == rsq_pkg::ST_PWR) || (stNext[d] == rsq_pkg::ST_PLL)
                             || (stNext[d] == rsq_pkg::ST_LOCK)
                             || (stNext[d] == rsq_pkg::ST_DP && fullNext[d]);
      ctlNext[d].dpReset   = (stNext[d] == rsq_pkg::ST_PWR) || (stNext[d] == rsq_pkg::ST_PLL)
                             || (stNext[d] == rsq_pkg::ST_LOCK) || (stNext[d] == rsq_pkg::ST_DP);
      ctlNext[d].userReady = (stNext[d] == rsq_pkg::ST_RDONE) || (stNext[d] == rsq_pkg::ST_DONE);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
        st_reg[d]   <= rsq_pkg::ST_IDLE;
        cnt_reg[d]  <= '0;
        skip_reg[d] <= 1'b0;
        full_reg[d] <= 1'b0;
        seen_reg[d] <= 1'b0;
        ctl_reg[d]  <= '0;
        done_reg[d] <= 1'b0;
      end else begin
        st_reg[d]   <= stNext[d];
        cnt_reg[d]  <= cntNext[d];
        skip_reg[d] <= skipNext[d];
        full_reg[d] <= fullNext[d];
        seen_reg[d] <= seenNext[d];
        ctl_reg[d]  <= ctlNext[d];
        done_reg[d] <= (stNext[d] == rsq_pkg::ST_DONE);
      end
    end
  end

  assign txCtl  = ctl_reg[0];
  assign rxCtl  = ctl_reg[1];
  assign txDone = done_reg[0];
  assign rxDone = done_reg[1];

  // AXI4-Lite slave, one write and one read in flight
  logic                      awready_reg;
  logic                      wready_reg;
  logic                      bvalid_reg;
  logic [1:0]                bresp_reg;
  logic                      arready_reg;
  logic                      rvalid_reg;
  logic [1:0]                rresp_reg;
  logic [31:0]               rdata_reg;
  logic [rsq_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0]               wdata_reg;
  logic                      wlane0_reg;

  wire  doWrite  = !awready_reg && !wready_reg && !bvalid_reg;
  wire  wrCtrl   = awaddr_reg == rsq_pkg::REG_CTRL[rsq_pkg::ADDR_W-1:0];
  wire  wrStat   = awaddr_reg == rsq_pkg::REG_STATUS[rsq_pkg::ADDR_W-1:0];
  wire  rdCtrl   = s_axi_araddr == rsq_pkg::REG_CTRL[rsq_pkg::ADDR_W-1:0];
  wire  rdStat   = s_axi_araddr == rsq_pkg::REG_STATUS[rsq_pkg::ADDR_W-1:0];
  wire  [31:0] statusWord;

  assign statusWord = {15'h0000, sync_reg[rsq_pkg::IN_PGOOD +: 5],
                       2'h0, done_reg,
                       st_reg[1], st_reg[0]};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awready_reg   <= 1'b1;
      wready_reg    <= 1'b1;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= rsq_pkg::RESP_OKAY;
      awaddr_reg    <= '0;
      wdata_reg     <= '0;
      wlane0_reg    <= 1'b0;
      ctrlPulse_reg <= '0;
    end else begin
      ctrlPulse_reg <= '0;
      if (s_axi_awvalid && awready_reg) begin
        awaddr_reg  <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        wdata_reg  <= s_axi_wdata;
        wlane0_reg <= s_axi_wstrb[0];
        wready_reg <= 1'b0;
      end
      if (doWrite) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wrCtrl || wrStat) ? rsq_pkg::RESP_OKAY : rsq_pkg::RESP_SLVERR;
        // Writes pulse requests; nothing is stored, so a stuck bit cannot hold a reset
        if (wrCtrl && wlane0_reg) ctrlPulse_reg <= wdata_reg[rsq_pkg::CTRL_W-1:0];
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= rsq_pkg::RESP_OKAY;
      rdata_reg   <= '0;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= (rdCtrl || rdStat) ? rsq_pkg::RESP_OKAY : rsq_pkg::RESP_SLVERR;
      rdata_reg   <= rdStat ? statusWord : 32'h0000_0000;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

endmodule

// file: src/rsq_pkg.sv
package rsq_pkg;

  // Timing of the sequence at the free-running clock rate
  localparam int CLK_MHZ      = 100;
  localparam int PLL_RST_NS   = 200;
  localparam int DP_RST_NS    = 100;
  localparam int PLL_RST_CYC  = (PLL_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int DP_RST_CYC   = (DP_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W        = 8;

  // Register map, byte addresses
  localparam logic [31:0] REG_CTRL   = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS = 32'h0000_0004;
  localparam int ADDR_W = 4;

  // Control register bits, each a one-cycle request pulse
  localparam int CTRL_ALL    = 0;
  localparam int CTRL_TX_PLL = 1;
  localparam int CTRL_TX_DP  = 2;
  localparam int CTRL_RX_PLL = 3;
  localparam int CTRL_RX_DP  = 4;
  localparam int CTRL_W      = 5;

  // Status register fields
  localparam int ST_TX_LSB   = 0;
  localparam int ST_RX_LSB   = 4;
  localparam int ST_DONE_LSB = 8;
  localparam int ST_IN_LSB   = 12;

  // Synchronised input vector positions
  localparam int IN_PGOOD   = 0;
  localparam int IN_LOCK    = 1;   // +dir
  localparam int IN_RDONE   = 3;   // +dir
  localparam int IN_UACT    = 5;   // +dir
  localparam int IN_UCLK    = 7;   // +dir
  localparam int IN_ALL     = 9;
  localparam int IN_PLLREQ  = 10;  // +dir
  localparam int IN_DPREQ   = 12;  // +dir
  localparam int IN_EN      = 14;  // +dir
  localparam int IN_SHARED  = 16;
  localparam int IN_W       = 17;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PWR, ST_PLL, ST_LOCK, ST_DP, ST_UCLK, ST_RDONE, ST_DONE
  } rsq_state_t;

  // Controls fanned out to the transceiver duals for one direction
  typedef struct packed {
    logic pllReset;
    logic divReset;
    logic dpReset;
    logic userReady;
  } rsq_ctl_t;

  // Status gathered from the transceiver duals for one direction
  typedef struct packed {
    logic pllLock;
    logic resetDone;
    logic userClkActive;
  } rsq_stat_t;

endpackage

// file: test/rsq_dual_model.sv
`timescale 1ns/1ps
module rsq_dual_model (
  input  wire logic               clock,   // Free-running clock
  input  wire logic               pllRst,  // Reset seen by the serving PLL
  input  wire rsq_pkg::rsq_ctl_t  ctl,     // Controls from the sequencer
  input  wire logic               uAct,    // User clocks running
  input  wire logic [4:0]         dly,     // Answer delay in cycles
  output rsq_pkg::rsq_stat_t      stat,    // Combined status of all duals
  output logic                    userClk  // Master channel second user clock
);
  logic [4:0] lockCnt = 5'h00;
  logic [4:0] doneCnt = 5'h00;
  initial userClk = 1'b0;
  // Stands still while the clocks are not active, so no toggle is seen
  always #3.3 if (uAct) userClk = ~userClk;
  always @(posedge clock) begin
    lockCnt <= pllRst ? 5'h00 : lockCnt + 5'(lockCnt < dly);
    doneCnt <= (ctl.dpReset || !ctl.userReady) ? 5'h00 : doneCnt + 5'(doneCnt < dly);
  end
  // One model stands for the AND over every dual and PLL
  // Saturated counts stay valid when the delay is lowered between runs
  assign stat.pllLock = !pllRst && lockCnt >= dly;
  assign stat.resetDone = !ctl.dpReset && ctl.userReady && doneCnt >= dly;
  assign stat.userClkActive = uAct;
endmodule

// file: test/rsq_seq_checker_props.sv
`timescale 1ns/1ps
module rsq_seq_checker (
  input wire logic               clock,        // Free-running clock
  input wire logic               sys_rst,      // Async reset
  input wire rsq_pkg::rsq_stat_t txStat,       // Transmit status
  input wire rsq_pkg::rsq_stat_t rxStat,       // Receive status
  input wire logic               resetAllReq,  // Global reset pulse
  input wire logic               txEnabledTie, // Transmit tie
  input wire logic               sharedPllTie, // Shared PLL tie
  input wire rsq_pkg::rsq_ctl_t  txCtl,        // Transmit controls
  input wire rsq_pkg::rsq_ctl_t  rxCtl,        // Receive controls
  input wire logic               txDone,       // Transmit done
  input wire logic               rxDone        // Receive done
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [7:0] pllCnt;
  logic [7:0] dpCnt;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pllCnt <= 8'h00;
      dpCnt  <= 8'h00;
    end else begin
      pllCnt <= txCtl.pllReset ? pllCnt + 8'(pllCnt != 8'hFF) : 8'h00;
      dpCnt  <= txCtl.dpReset ? dpCnt + 8'(dpCnt != 8'hFF) : 8'h00;
    end
  end
  property p_pll_hold; $fell(txCtl.pllReset) |-> pllCnt >= rsq_pkg::PLL_RST_CYC; endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("pll reset too short");
  property p_dp_hold; $fell(txCtl.dpReset) |-> dpCnt >= rsq_pkg::DP_RST_CYC; endproperty
  a_dp_hold: assert property (p_dp_hold) else $error("datapath reset too short");
  property p_ready; txCtl.userReady |-> !txCtl.dpReset && !txCtl.pllReset; endproperty
  a_ready: assert property (p_ready) else $error("ready during reset");
  property p_done; $rose(txDone) |-> $past(txStat.resetDone, 2) && txCtl.userReady; endproperty
  a_done: assert property (p_done) else $error("done before reset-done");
  property p_uact; $rose(rxDone) |-> $past(rxStat.userClkActive, 2); endproperty
  a_uact: assert property (p_uact) else $error("done without active clocks");
  property p_shared; sharedPllTie |-> !rxCtl.pllReset; endproperty
  a_shared: assert property (p_shared) else $error("shared pll reset twice");
  property p_park;
    (resetAllReq && txEnabledTie)[*5] |=> txCtl.pllReset && txCtl.dpReset && !txDone;
  endproperty
  a_park: assert property (p_park) else $error("not parked in reset");
  property p_rxlock; $rose(rxCtl.userReady) |-> $past(rxStat.pllLock, 2); endproperty
  a_rxlock: assert property (p_rxlock) else $error("ready before lock");
endmodule
bind rsq_transceiver_reset_sequencer rsq_seq_checker i_chk (.clock, .sys_rst, .txStat,
  .rxStat, .resetAllReq, .txEnabledTie, .sharedPllTie, .txCtl, .rxCtl, .txDone, .rxDone);

// file: test/rsq_transceiver_reset_sequencer_tb_top.sv
`timescale 1ns/1ps
module rsq_transceiver_reset_sequencer_tb_top;
  localparam logic [3:0] CT = rsq_pkg::REG_CTRL[3:0];
  localparam logic [3:0] ST = rsq_pkg::REG_STATUS[3:0];
  logic clock = 1'b0, sys_rst = 1'b1, powerGood = 1'b0, resetAllReq = 1'b0;
  logic [3:0] req = 4'h0;
  logic [2:0] tie = 3'b011;
  logic [1:0] uAct = 2'b11;
  logic [4:0] dly = 5'h02;
  rsq_pkg::rsq_stat_t txStat, rxStat;
  rsq_pkg::rsq_ctl_t txCtl, rxCtl;
  logic txClk, rxClk, txDone, rxDone;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [33:0] expQ[$];
  int errors = 0, comparisons = 0;
  int hi[4];
  wire [3:0] rstNow = {rxCtl.dpReset, rxCtl.pllReset, txCtl.dpReset, txCtl.pllReset};
  always #5 clock = ~clock;
  rsq_transceiver_reset_sequencer i_rsq_transceiver_reset_sequencer (.clock, .sys_rst,
    .powerGood, .txStat, .rxStat, .tx_master_user_clock_b(txClk),
    .rx_master_user_clock_b(rxClk), .resetAllReq, .txPllDpReq(req[3]), .txDpReq(req[2]),
    .rxPllDpReq(req[1]), .rxDpReq(req[0]), .txEnabledTie(tie[0]), .rxEnabledTie(tie[1]),
    .sharedPllTie(tie[2]), .txCtl, .rxCtl, .txDone, .rxDone, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  rsq_dual_model i_tx_model (.clock, .pllRst(txCtl.pllReset), .ctl(txCtl), .uAct(uAct[0]),
    .dly, .stat(txStat), .userClk(txClk));
  // With a shared PLL the receive lock follows the transmit PLL reset
  rsq_dual_model i_rx_model (.clock, .pllRst(rxCtl.pllReset | (tie[2] & txCtl.pllReset)),
    .ctl(rxCtl), .uAct(uAct[1]), .dly, .stat(rxStat), .userClk(rxClk));
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Status word: synced inputs, done bits and both state codes
  function automatic logic [33:0] st(input logic [4:0] i, input logic [1:0] d,
                                     input logic [3:0] rx, tx);
    return {rsq_pkg::RESP_OKAY, 15'h0000, i, 2'h0, d, rx, tx};
  endfunction
  task automatic axWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    expQ.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic axRead(input logic [3:0] a, input logic [33:0] e);
    @(posedge clock);
    expQ.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  // Held past the two synchroniser flops so no request is lost
  task automatic pulse(input int which);
    int w;
    w = 4 + $urandom % 4;
    if (which == 4) resetAllReq <= 1'b1;
    else req[which] <= 1'b1;
    repeat (w) @(posedge clock);
    resetAllReq <= 1'b0;
    req <= 4'h0;
    @(posedge clock);
  endtask
  task automatic waitFor(input logic [1:0] w);
    int n;
    n = 0;
    while ((({rxDone, txDone} & w) !== w) && n < 3000) begin
      @(posedge clock);
      n++;
    end
    check("done", 34'({rxDone, txDone} & w), 34'(w));
  endtask
  task automatic touched(input int b[4], input logic [3:0] want);
    for (int i = 0; i < 4; i++) begin
      check("reset touched", 34'(hi[i] != b[i]), 34'(want[i]));
    end
  endtask
  always @(posedge clock) begin
    foreach (hi[i]) hi[i] += int'(rstNow[i]);
    if (bvalid && bready) check("write resp", {bresp, 32'h0}, expQ.pop_front());
    if (rvalid && rready) check("read", {rresp, rdata}, expQ.pop_front());
  end
  initial begin
    #600000;
    errors++;
    finish_test();
  end
  initial begin
    int b[4];
    logic [2:0] cfg[3] = '{3'b001, 3'b010, 3'b111};
    logic [3:0] wantR[5] = '{4'b1000, 4'b1100, 4'b0010, 4'b0011, 4'b1111};
    void'($urandom(69));
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    uAct <= 2'b01;
    pulse(4);
    repeat (30) @(posedge clock);
    axRead(ST, st(5'h00, 2'b00, 4'h1, 4'h1));
    powerGood <= 1'b1;
    waitFor(2'b01);
    repeat (40) @(posedge clock);
    axRead(ST, st(5'h0F, 2'b01, 4'h5, 4'h7));
    uAct <= 2'b11;
    waitFor(2'b11);
    axRead(ST, st(5'h1F, 2'b11, 4'h7, 4'h7));
    foreach (cfg[k]) begin
      tie <= cfg[k];
      dly <= 5'($urandom % 24);
      repeat (4) @(posedge clock);
      b = hi;
      pulse(4);
      waitFor(cfg[k][1:0]);
      touched(b, {cfg[k][1], cfg[k][1] & ~cfg[k][2], cfg[k][0], cfg[k][0]});
      axRead(ST, st(5'h1F, 2'b11, 4'h7, 4'h7));
    end
    tie <= 3'b011;
    for (int r = 0; r < 5; r++) begin
      b = hi;
      if (r == 4 || r % 2 == 1) axWrite(CT, 32'h1 << (4 - r), rsq_pkg::RESP_OKAY);
      else pulse(r);
      repeat (8) @(posedge clock);
      waitFor(2'b11);
      touched(b, wantR[r]);
    end
    axRead(CT, {rsq_pkg::RESP_OKAY, 32'h0});
    axRead(4'h8, {rsq_pkg::RESP_SLVERR, 32'h0});
    axWrite(4'hC, 32'h1, rsq_pkg::RESP_SLVERR);
    axWrite(ST, 32'h0, rsq_pkg::RESP_OKAY);
    axRead(ST, st(5'h1F, 2'b11, 4'h7, 4'h7));
    finish_test();
  end
endmodule
